// ==== core/lpmc_ctrl.sv ====
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lpmc_params.svh"

module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int REC_LONG  = `LPMC_REC_LONG,
  parameter int REC_SHORT = `LPMC_REC_SHORT
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`LPMC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Processor core
  input  wire logic                     wait_req,
  input  wire logic                     stop_req,
  output logic                          cpu_imask,
  output lpmc_src_t                     wake_vector,
  // Module requests
  input  wire lpmc_wake_t               wake_in,
  input  wire logic                     wdt_timeout,
  input  wire logic                     lvm_trip,
  // Clock and module controls
  output lpmc_outs_t                    lp_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    lpmc_mode_t  mode;
    lpmc_ctrl_t  ctrl;
    logic        imask;
    logic        brk_flag;
    logic        exit_reset;
    logic        rec_start;
    lpmc_src_t   src;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    lpmc_outs_t  outs;
  } lpmc_state_t;

  lpmc_state_t s_r;
  lpmc_state_t s_nxt;
  logic        rec_busy;
  logic        rec_done;
  logic        reset_req;
  lpmc_wake_t  wake_wait;
  lpmc_wake_t  wake_stop;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic lpmc_src_t wake_pick(input lpmc_wake_t w);
    lpmc_src_t r;
    r = LPMC_SRC_NONE;
    if (w.ext) r = LPMC_SRC_EXT;
    else if (w.break_unit) r = LPMC_SRC_BRK;
    else if (w.cgen) r = LPMC_SRC_CGEN;
    else if (w.key) r = LPMC_SRC_KEY;
    else if (w.tim) r = LPMC_SRC_TIM;
    else if (w.spi) r = LPMC_SRC_SPI;
    else if (w.sci) r = LPMC_SRC_SCI;
    else if (w.adc) r = LPMC_SRC_ADC;
    return r;
  endfunction

  // Static per-mode levels; pulses are added by the caller
  function automatic lpmc_outs_t mode_outs(input lpmc_mode_t m, input lpmc_ctrl_t c);
    lpmc_outs_t o;
    logic       stp;
    logic       run;
    stp = (m == LPMC_STOP);
    run = (m == LPMC_RUN) || (m == LPMC_WAIT);
    o   = '0;
    o.cpu_clk_en  = (m == LPMC_RUN);
    // bus clock in stop follows oscillator choice
    o.bus_clk_en  = run || (stp && c.osc_run_in_stop);
    // oscillator and generator outputs off in stop unless osc_stop_enable is set
    o.osc_en      = !stp || c.osc_stop_enable;
    o.gen_out_en  = !stp || c.osc_stop_enable;
    o.pll_en      = !stp;
    // watchdog reference removed, prescaler held clear
    o.wdt_ref_en  = !stp;
    o.wdt_pre_clr = stp;
    // converter idle only while stopped or recovering
    o.adc_run     = run;
    // break unit only if enabled and not stopped
    o.brk_run     = run && c.brk_en;
    o.sci_run     = run;
    // serial peripheral and timers active in wait
    o.spi_run     = run;
    o.tim_run     = run;
    o.ext_run     = 1'b1;
    o.key_run     = 1'b1;
    o.lvm_run     = c.lvm_en;
    return o;
  endfunction

  always_comb begin
    wake_stop      = '0;
    wake_stop.ext  = wake_in.ext && !s_r.ctrl.ext_irq_mask;
    wake_stop.key  = wake_in.key && !s_r.ctrl.keypad_irq_mask;
    wake_stop.break_unit  = wake_in.break_unit && s_r.ctrl.brk_en;
    // peripherals that only wake from wait
    wake_wait      = wake_in;
    wake_wait.ext  = wake_stop.ext;
    wake_wait.key  = wake_stop.key;
    wake_wait.break_unit  = wake_stop.break_unit;
  end

  // watchdog unclocked in stop cannot time out there
  assign reset_req = (wdt_timeout && s_r.ctrl.wdt_en && (s_r.mode != LPMC_STOP))
                   || (lvm_trip && s_r.ctrl.lvm_en && s_r.ctrl.lvm_rst_en);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt           = s_r;
    s_nxt.pready    = 1'b0;
    s_nxt.pslverr   = 1'b0;
    s_nxt.rec_start = 1'b0;

    // APB setup cycle prepares the answer for the access phase
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = '0;
      unique case (paddr)
        `LPMC_CTRL_OFS: s_nxt.prdata[`LPMC_CTRL_W-1:0] = s_r.ctrl;
        `LPMC_STAT_OFS: begin
          s_nxt.prdata[`LPMC_S_MODE_LSB +: 2] = s_r.mode;
          s_nxt.prdata[`LPMC_S_IMASK]         = s_r.imask;
          s_nxt.prdata[`LPMC_S_CPU_CLK]       = s_r.outs.cpu_clk_en;
          s_nxt.prdata[`LPMC_S_BUS_CLK]       = s_r.outs.bus_clk_en;
          s_nxt.prdata[`LPMC_S_OSC]           = s_r.outs.osc_en;
          s_nxt.prdata[`LPMC_S_PLL]           = s_r.outs.pll_en;
          s_nxt.prdata[`LPMC_S_REC_BUSY]      = rec_busy;
          s_nxt.prdata[`LPMC_S_BRK_FLAG]      = s_r.brk_flag;
          s_nxt.prdata[`LPMC_S_SRC_LSB +: 4]  = s_r.src;
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
      if (paddr == `LPMC_CTRL_OFS) begin
        s_nxt.ctrl = pwdata[`LPMC_CTRL_W-1:0];
      end
      if (paddr == `LPMC_STAT_OFS && pwdata[`LPMC_S_BRK_FLAG]) begin
        s_nxt.brk_flag = 1'b0;
      end
    end

    unique case (s_r.mode)
      LPMC_RUN: begin
        if (reset_req) begin
          s_nxt.imask = 1'b1;
        end else if (wait_req) begin
          s_nxt.mode  = LPMC_WAIT;
          s_nxt.imask = 1'b0;
        end else if (stop_req && s_r.ctrl.stop_en) begin
          s_nxt.mode  = LPMC_STOP;
          s_nxt.imask = 1'b0;
        end
      end
      LPMC_WAIT: begin
        // restart on reset or enabled request
        if (reset_req) begin
          s_nxt.mode  = LPMC_RUN;
          s_nxt.imask = 1'b1;
          s_nxt.src   = LPMC_SRC_RESET;
        end else if (wake_pick(wake_wait) != LPMC_SRC_NONE) begin
          s_nxt.mode = LPMC_RUN;
          s_nxt.src  = wake_pick(wake_wait);
        end
      end
      LPMC_STOP: begin
        // break flag set; placed after the clear so the set wins
        if (wake_stop.break_unit) begin
          s_nxt.brk_flag = 1'b1;
        end
        if (reset_req) begin
          s_nxt.mode       = LPMC_RECOVER;
          s_nxt.imask      = 1'b1;
          s_nxt.exit_reset = 1'b1;
          s_nxt.rec_start  = 1'b1;
          s_nxt.src        = LPMC_SRC_RESET;
        end else if (wake_pick(wake_stop) != LPMC_SRC_NONE) begin
          s_nxt.mode       = LPMC_RECOVER;
          s_nxt.exit_reset = 1'b0;
          s_nxt.rec_start  = 1'b1;
          s_nxt.src        = wake_pick(wake_stop);
        end
      end
      LPMC_RECOVER: begin
        // clocks held until the counter finishes
        if (rec_done) begin
          s_nxt.mode = LPMC_RUN;
        end
      end
    endcase

    s_nxt.outs = mode_outs(s_nxt.mode, s_nxt.ctrl);
    // restart pulse when the CPU clock comes back
    s_nxt.outs.cpu_restart = (s_r.mode != LPMC_RUN) && (s_nxt.mode == LPMC_RUN);
    s_nxt.outs.adc_abort   = (s_r.mode == LPMC_RUN) && (s_nxt.mode == LPMC_STOP);
    // serial peripheral reset on reset exit from stop
    s_nxt.outs.spi_reset   = (s_r.mode == LPMC_STOP) && reset_req;
    s_nxt.outs.sys_reset   = reset_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r            <= '0;
      s_r.mode       <= LPMC_RUN;
      s_r.ctrl       <= `LPMC_CTRL_RST;
      s_r.imask      <= 1'b1;
      s_r.outs       <= mode_outs(LPMC_RUN, `LPMC_CTRL_RST);
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Stop recovery counter
  // ****************************************************************
  lpmc_recovery #(
    .LONG_CYC  (REC_LONG),
    .SHORT_CYC (REC_SHORT),
    .CNT_W     (`LPMC_REC_CNT_W)
  ) u_rec (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (s_r.rec_start),
    .short_sel (s_r.ctrl.short_stop_recovery),
    .busy_r    (rec_busy),
    .done_r    (rec_done)
  );

  assign prdata      = s_r.prdata;
  assign pready      = s_r.pready;
  assign pslverr     = s_r.pslverr;
  assign cpu_imask   = s_r.imask;
  assign wake_vector = s_r.src;
  assign lp_out      = s_r.outs;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Restart lands REC_SHORT + 2 edges after recovery entry; window scales with the count
  localparam int SR_LO = REC_SHORT - 6, SR_HI = REC_SHORT - 4;

  sequence s_stop_int_exit;
    (s_r.mode == LPMC_STOP) && !reset_req && (wake_pick(wake_stop) != LPMC_SRC_NONE);
  endsequence

  sequence s_short_rec;
    s_stop_int_exit ##1 (s_r.mode == LPMC_RECOVER) && s_r.ctrl.short_stop_recovery;
  endsequence

  property p_wait_clocks;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_WAIT) |-> !lp_out.cpu_clk_en && lp_out.bus_clk_en;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("wait clocks wrong");

  property p_stop_bus;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_STOP) |-> !lp_out.cpu_clk_en
        && (lp_out.bus_clk_en == s_r.ctrl.osc_run_in_stop);
  endproperty
  a_stop_bus: assert property (p_stop_bus) else $error("stop bus clock wrong");

  property p_wait_mask;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_RUN && !reset_req && wait_req) |=> !cpu_imask && s_r.mode == LPMC_WAIT;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("wait did not clear mask");

  property p_stop_reset_mask;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_STOP && reset_req) |=> cpu_imask && lp_out.spi_reset;
  endproperty
  a_stop_reset_mask: assert property (p_stop_reset_mask) else $error("reset exit mask");

  property p_rec_hold;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_RECOVER) |-> !lp_out.cpu_clk_en && !lp_out.bus_clk_en;
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("clock during recovery");

  property p_short_rec;
    @(posedge pclk) disable iff (!presetn)
      s_short_rec |-> !lp_out.cpu_restart [*8] ##[SR_LO:SR_HI] lp_out.cpu_restart;
  endproperty
  a_short_rec: assert property (p_short_rec) else $error("short recovery length");

  property p_osc_stop;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_STOP) |-> !lp_out.pll_en
        && (lp_out.osc_en == s_r.ctrl.osc_stop_enable)
        && (lp_out.gen_out_en == s_r.ctrl.osc_stop_enable);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator control in stop");

  property p_wdt_stop;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_STOP) |-> !lp_out.wdt_ref_en && lp_out.wdt_pre_clr;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog not parked");

  property p_stop_gate;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_RUN && stop_req && !wait_req && !s_r.ctrl.stop_en) |=>
        (s_r.mode == LPMC_RUN);
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("stop taken while disabled");

  property p_adc_abort;
    @(posedge pclk) disable iff (!presetn)
      $rose(s_r.mode == LPMC_STOP) |-> lp_out.adc_abort && !lp_out.adc_run && !lp_out.tim_run;
  endproperty
  a_adc_abort: assert property (p_adc_abort) else $error("converter not aborted");

  property p_brk_flag;
    @(posedge pclk) disable iff (!presetn)
      (s_r.mode == LPMC_STOP && wake_stop.break_unit) |=> s_r.brk_flag;
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break flag not set");

endmodule

// ==== core/lpmc_params.svh ====
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define LPMC_ADDR_W          12
`define LPMC_CTRL_OFS        12'h000
`define LPMC_STAT_OFS        12'h004

// ****************************************************************
// Control register fields
// ****************************************************************
`define LPMC_CTRL_W          10
`define LPMC_CTRL_RST        10'h0c0
`define LPMC_B_OSC_RUN_STOP  0
`define LPMC_B_OSC_STOP_EN   1
`define LPMC_B_SHORT_REC     2
`define LPMC_B_STOP_EN       3
`define LPMC_B_EXT_MASK      4
`define LPMC_B_KEY_MASK      5
`define LPMC_B_LVM_EN        6
`define LPMC_B_LVM_RST_EN    7
`define LPMC_B_BRK_EN        8
`define LPMC_B_WDT_EN        9

// ****************************************************************
// Status register fields
// ****************************************************************
`define LPMC_S_MODE_LSB      0
`define LPMC_S_IMASK         2
`define LPMC_S_CPU_CLK       3
`define LPMC_S_BUS_CLK       4
`define LPMC_S_OSC           5
`define LPMC_S_PLL           6
`define LPMC_S_REC_BUSY      7
`define LPMC_S_BRK_FLAG      8
`define LPMC_S_SRC_LSB       12

// ****************************************************************
// Stop recovery counts, in reference clock cycles
// ****************************************************************
`define LPMC_REC_LONG        4096
`define LPMC_REC_SHORT       32
`define LPMC_REC_CNT_W       12

`endif

// ==== core/lpmc_pkg.sv ====
package lpmc_pkg;

  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_WAIT,
    LPMC_STOP,
    LPMC_RECOVER
  } lpmc_mode_t;

  typedef enum logic [3:0] {
    LPMC_SRC_NONE,
    LPMC_SRC_RESET,
    LPMC_SRC_EXT,
    LPMC_SRC_BRK,
    LPMC_SRC_CGEN,
    LPMC_SRC_KEY,
    LPMC_SRC_TIM,
    LPMC_SRC_SPI,
    LPMC_SRC_SCI,
    LPMC_SRC_ADC
  } lpmc_src_t;

  typedef struct packed {
    logic wdt_en;
    logic brk_en;
    logic lvm_rst_en;
    logic lvm_en;
    logic keypad_irq_mask;
    logic ext_irq_mask;
    logic stop_en;
    logic short_stop_recovery;
    logic osc_stop_enable;
    logic osc_run_in_stop;
  } lpmc_ctrl_t;

  typedef struct packed {
    logic ext;
    logic key;
    logic break_unit;
    logic cgen;
    logic tim;
    logic spi;
    logic sci;
    logic adc;
  } lpmc_wake_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic osc_en;
    logic pll_en;
    logic gen_out_en;
    logic wdt_ref_en;
    logic wdt_pre_clr;
    logic adc_run;
    logic brk_run;
    logic sci_run;
    logic spi_run;
    logic tim_run;
    logic ext_run;
    logic key_run;
    logic lvm_run;
    logic cpu_restart;
    logic adc_abort;
    logic spi_reset;
    logic sys_reset;
  } lpmc_outs_t;

endpackage

// ==== core/lpmc_recovery.sv ====
`timescale 1ns/1ps
`include "lpmc_params.svh"

module lpmc_recovery
  import lpmc_pkg::*;
#(
  parameter int LONG_CYC  = `LPMC_REC_LONG,
  parameter int SHORT_CYC = `LPMC_REC_SHORT,
  parameter int CNT_W     = `LPMC_REC_CNT_W
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  input  wire logic short_sel,
  // Status
  output logic      busy_r,
  output logic      done_r
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
  } lpmc_rec_state_t;

  lpmc_rec_state_t s_r;
  lpmc_rec_state_t s_nxt;

  // Busy stays high for exactly the selected number of cycles
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = short_sel ? CNT_W'(SHORT_CYC - 1) : CNT_W'(LONG_CYC - 1);
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_r = s_r.busy;
  assign done_r = s_r.done;

endmodule

// ==== testbench/lpmc_core_model.sv ====
`timescale 1ns/1ps

module lpmc_core_model
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench commands
  input  wire logic go_wait,
  input  wire logic go_stop,
  // Block side
  input  wire logic cpu_clk_en,
  input  wire logic cpu_restart,
  output logic      wait_req,
  output logic      stop_req,
  output int        restarts
);
  // requests and restart accept
  // The core only executes an instruction while its own clock runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_req <= 1'b0;
      stop_req <= 1'b0;
      restarts <= 0;
    end else begin
      wait_req <= go_wait & cpu_clk_en;
      stop_req <= go_stop & cpu_clk_en;
      if (cpu_restart) begin
        restarts <= restarts + 1;
      end
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "lpmc_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module tb_top
  import lpmc_pkg::*;
;
  localparam int NL = 64;
  localparam int NS = 8;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, cpu_imask, wait_req, stop_req;
  logic        go_wait = 0, go_stop = 0, wdt_timeout = 0, lvm_trip = 0;
  lpmc_src_t   wake_vector;
  lpmc_wake_t  wake_in = '0;
  lpmc_outs_t  lp_out;
  int          fail_count, num_checks, cyc, abort_n, spirst_n, sysrst_n, restarts, k, early, n;
  logic [31:0] cfg;
  lpmc_src_t   exp_src [8] = '{LPMC_SRC_ADC, LPMC_SRC_SCI, LPMC_SRC_SPI, LPMC_SRC_TIM,
                               LPMC_SRC_CGEN, LPMC_SRC_BRK, LPMC_SRC_KEY, LPMC_SRC_EXT};

  always #12.5 pclk = ~pclk;

  lpmc_ctrl #(.REC_LONG(NL), .REC_SHORT(NS)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_req(wait_req),
    .stop_req(stop_req), .cpu_imask(cpu_imask), .wake_vector(wake_vector),
    .wake_in(wake_in), .wdt_timeout(wdt_timeout), .lvm_trip(lvm_trip), .lp_out(lp_out));

  lpmc_core_model u_core (.pclk(pclk), .presetn(presetn), .go_wait(go_wait),
    .go_stop(go_stop), .cpu_clk_en(lp_out.cpu_clk_en), .cpu_restart(lp_out.cpu_restart),
    .wait_req(wait_req), .stop_req(stop_req), .restarts(restarts));

  // ************************************************************
  // Pulse counters and hang guard
  // ************************************************************
  always @(posedge pclk) begin
    cyc++;
    if (lp_out.adc_abort === 1'b1) abort_n++;
    if (lp_out.spi_reset === 1'b1) spirst_n++;
    if (lp_out.sys_reset === 1'b1) sysrst_n++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hang here
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Issue one instruction, let the mode change land
  task automatic go(input bit st);
    @(posedge pclk);
    if (st) go_stop <= 1'b1;
    else go_wait <= 1'b1;
    @(posedge pclk);
    go_wait <= 1'b0; go_stop <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // Raise a wake cause, count edges to restart; flag clocks that come early
  task automatic wake(input lpmc_wake_t w, input bit wd, input bit lv);
    @(posedge pclk);
    wake_in <= w; wdt_timeout <= wd; lvm_trip <= lv;
    k = 0; early = 0;
    while (lp_out.cpu_restart !== 1'b1 && k < 300) begin
      @(posedge pclk);
      #1;
      k++;
      if (lp_out.cpu_restart !== 1'b1 && lp_out.cpu_clk_en === 1'b1) early++;
    end
    @(posedge pclk);
    wake_in <= '0; wdt_timeout <= 1'b0; lvm_trip <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    void'($urandom(80792));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK(cpu_imask, 1'b1) // reset level
    `CHK({lp_out.cpu_clk_en, lp_out.bus_clk_en, lp_out.osc_en, lp_out.pll_en}, 4'hf)
    apb(1'b0, `LPMC_CTRL_OFS, '0);
    `CHK(rd[9:0], 10'h0c0) // defaults
    apb(1'b0, 12'h010, '0);
    `CHK(er, 1'b1) // unmapped refused
    // Wait mode, every wake source in turn
    apb(1'b1, `LPMC_CTRL_OFS, 32'h1c0);
    for (int b = 0; b < 8; b++) begin
      go(1'b0);
      `CHK({lp_out.cpu_clk_en, lp_out.bus_clk_en, cpu_imask}, 3'b010)
      `CHK({lp_out.adc_run, lp_out.tim_run, lp_out.spi_run, lp_out.sci_run}, 4'hf)
      `CHK({lp_out.ext_run, lp_out.key_run, lp_out.lvm_run, lp_out.brk_run}, 4'hf)
      n = restarts;
      repeat ($urandom_range(1, 6)) @(posedge pclk);
      wake(lpmc_wake_t'(8'h01 << b), 1'b0, 1'b0);
      `CHK(k, 1) // prompt restart
      `CHK(wake_vector, exp_src[b]) // vector
      `CHK(cpu_imask, 1'b0) // stays clear
      `CHK(restarts, n + 1)
    end
    // Stop refused while stop enable is clear
    n = abort_n;
    go(1'b1);
    `CHK({lp_out.cpu_clk_en, abort_n[7:0]}, {1'b1, n[7:0]})
    // Stop under every oscillator setting, random recovery length
    for (int c = 0; c < 4; c++) begin
      cfg = 32'h2c8 | c | ($urandom_range(0, 1) << 2);
      apb(1'b1, `LPMC_CTRL_OFS, cfg);
      n = abort_n;
      go(1'b1);
      `CHK({lp_out.cpu_clk_en, lp_out.bus_clk_en, cpu_imask}, {1'b0, cfg[0], 1'b0})
      `CHK({lp_out.osc_en, lp_out.gen_out_en, lp_out.pll_en}, {cfg[1], cfg[1], 1'b0})
      `CHK({lp_out.wdt_ref_en, lp_out.wdt_pre_clr}, 2'b01)
      `CHK(abort_n, n + 1) // abort
      `CHK({lp_out.adc_run, lp_out.tim_run, lp_out.sci_run, lp_out.spi_run}, 4'h0)
      `CHK({lp_out.brk_run, lp_out.ext_run, lp_out.key_run, lp_out.lvm_run}, 4'h7)
      wake('0, 1'b1, 1'b0);
      `CHK(k, 300) // timeout ignored in stop
      wake(lpmc_wake_t'(8'h80), 1'b0, 1'b0);
      n = cfg[2] ? NS : NL;
      `CHK(k >= n + 2 && k <= n + 4, 1'b1)
      `CHK(early, 0)
      `CHK({wake_vector, cpu_imask}, {LPMC_SRC_EXT, 1'b0})
      `CHK({lp_out.adc_run, lp_out.tim_run, lp_out.spi_run}, 3'h7)
    end
    // Masked external request must not wake; keypad raised in the same cycle does
    apb(1'b1, `LPMC_CTRL_OFS, 32'h0dc);
    go(1'b1);
    wake(lpmc_wake_t'(8'hc0), 1'b0, 1'b0);
    `CHK(wake_vector, LPMC_SRC_KEY)
    // Watchdog reset ends wait
    apb(1'b1, `LPMC_CTRL_OFS, 32'h2c8);
    go(1'b0);
    n = sysrst_n;
    wake('0, 1'b1, 1'b0);
    `CHK({wake_vector, cpu_imask, sysrst_n > n}, {LPMC_SRC_RESET, 2'b11})
    // Monitor reset ends stop, serial peripheral is reset
    n = spirst_n;
    go(1'b1);
    wake('0, 1'b0, 1'b1);
    `CHK({wake_vector, cpu_imask, spirst_n}, {LPMC_SRC_RESET, 1'b1, n + 1})
    // Break ends stop and raises the flag; write one clears it
    apb(1'b1, `LPMC_CTRL_OFS, 32'h1cc);
    go(1'b1);
    wake(lpmc_wake_t'(8'h20), 1'b0, 1'b0);
    apb(1'b0, `LPMC_STAT_OFS, '0);
    `CHK({rd[8], rd[15:12]}, {1'b1, LPMC_SRC_BRK})
    apb(1'b1, `LPMC_STAT_OFS, 32'h100);
    apb(1'b0, `LPMC_STAT_OFS, '0);
    `CHK(rd[8], 1'b0) // flag clear
    end_sim();
  end
endmodule
